// ---- rtl/sarhi_pkg.sv ----
// Shared constants of the converter host interface.
// Assumes a 100 MHz ref_clk.
package sarhi_pkg;
	localparam int RESULT_W = 12;
	localparam int BUS_W = 8;
	localparam int CLK_MHZ = 100;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int AZ_MIN_US = 10;
	localparam int AZ_CYCLES = AZ_MIN_US * CLK_MHZ;
	localparam int CONV_TYP_US = 120;
	localparam int STEP_CYCLES = ((CONV_TYP_US - AZ_MIN_US) * CLK_MHZ) / RESULT_W;
	// ------------------------------------------------------------
	// Bus layout
	// ------------------------------------------------------------
	localparam int STATUS_POS = 7;
	localparam int HIGH_NIB_W = 4;
	localparam logic [2:0] PAD_ZERO = 3'h0;
	localparam logic [11:0] RESULT_RST = 12'h000;
	localparam logic [11:0] MSB_ONE = 12'h800;
	typedef enum logic [1:0] {
		SARHI_IDLE = 2'b00,
		SARHI_START = 2'b01,
		SARHI_AZ = 2'b10,
		SARHI_CONV = 2'b11
	} sarhi_state_t;
endpackage

// ---- rtl/sarhi_sync.sv ----
// Two-flop synchroniser for a single pin.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ns
module sarhi_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic d,
	output logic q
);
	logic s1_q;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_q <= RST_VAL;
			q <= RST_VAL;
		end else begin
			s1_q <= d;
			q <= s1_q;
		end
	end
endmodule

// ---- rtl/sarhi_bus.sv ----
// Data bus driver: byte select and status packing.
// Assumes synchronised strobes from the control block.
`timescale 1ns/1ns
module sarhi_bus
	import sarhi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic read_en,
	input wire logic byte_select,
	input wire logic converting,
	input wire logic [sarhi_pkg::RESULT_W-1:0] sar_bits,
	output logic [sarhi_pkg::BUS_W-1:0] data_out,
	output logic data_oe
);
	logic [BUS_W-1:0] data_d, data_q;
	logic oe_d, oe_q;
	always_comb begin
		oe_d = read_en;
		if (byte_select) begin
			data_d = {converting, PAD_ZERO, sar_bits[RESULT_W-1 -: HIGH_NIB_W]};
		end else begin
			data_d = sar_bits[BUS_W-1:0];
		end
	end
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			data_q <= '0;
			oe_q <= 1'b0;
		end else begin
			data_q <= data_d;
			oe_q <= oe_d;
		end
	end
	assign data_out = data_q;
	assign data_oe = oe_q;
endmodule

// ---- rtl/sarhi_top.sv ----
// Control logic of a 12-bit successive-approximation converter host interface.
// Assumes an external comparator result on comp_in, and pins from an async host.
//
// Summary of operation
// - Chip select plus write starts conversion
// - Drive bus only during chip-selected read
// - Byte select picks high or low byte
// - Busy low during conversion, high otherwise
// - High byte bit seven is status flag
// - Three pad bits read zero
// - Right-justified 12-bit result, bit 11 MSB
// - Auto-zero whenever idle and at start
// - Auto-zero lasts at least 10 us in internal mode; external mode relies on the host's write length
// - Internal pacing times auto-zero after write
// - Twelve bit decisions, MSB first, faster pace
// - External: MSB on second falling edge
// - Reads mid-conversion show partial register
// - Write during conversion restarts everything
// - Internal conversion about 120 us
`timescale 1ns/1ns
module sarhi_top
	import sarhi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic byte_select,
	input wire logic ext_clk,
	input wire logic use_ext_clk,
	input wire logic comp_in,
	output logic [sarhi_pkg::BUS_W-1:0] data_out,
	output logic data_oe,
	output logic busy_n,
	output logic hold_capacitor,
	output logic [sarhi_pkg::RESULT_W-1:0] dac_code
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic cs_n_s, rd_n_s, wr_n_s, bsel_s, eclk_s, comp_s, ext_mode_s;
	sarhi_sync #(.RST_VAL(1'b1)) u_cs (.clk(ref_clk), .reset(reset), .d(chip_select_n), .q(cs_n_s));
	sarhi_sync #(.RST_VAL(1'b1)) u_rd (.clk(ref_clk), .reset(reset), .d(read_n), .q(rd_n_s));
	sarhi_sync #(.RST_VAL(1'b1)) u_wr (.clk(ref_clk), .reset(reset), .d(write_n), .q(wr_n_s));
	sarhi_sync #(.RST_VAL(1'b0)) u_bs (.clk(ref_clk), .reset(reset), .d(byte_select), .q(bsel_s));
	sarhi_sync #(.RST_VAL(1'b0)) u_ec (.clk(ref_clk), .reset(reset), .d(ext_clk), .q(eclk_s));
	sarhi_sync #(.RST_VAL(1'b0)) u_cp (.clk(ref_clk), .reset(reset), .d(comp_in), .q(comp_s));
	// Pacing mode is a strap, but it still arrives from outside the clock domain
	sarhi_sync #(.RST_VAL(1'b0)) u_em (.clk(ref_clk), .reset(reset), .d(use_ext_clk), .q(ext_mode_s));

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// Busy covers every phase from the accepted write to the last decision
	function automatic logic is_running(input sarhi_state_t s);
		is_running = (s != SARHI_IDLE);
	endfunction

	// The input stays on the hold capacitor until bit decisions begin
	function automatic logic is_sampling(input sarhi_state_t s);
		is_sampling = (s == SARHI_IDLE) || (s == SARHI_START) || (s == SARHI_AZ);
	endfunction

	// A write only counts as a restart once the start phase has been left
	function automatic logic is_restartable(input sarhi_state_t s);
		is_restartable = (s == SARHI_AZ) || (s == SARHI_CONV);
	endfunction

	// Drops the bit under test if the comparator rejected it, then tries the next one
	function automatic logic [RESULT_W-1:0] trial_next(
		input logic [RESULT_W-1:0] sar,
		input logic [RESULT_W-1:0] mask,
		input logic keep
	);
		trial_next = (keep ? sar : (sar & ~mask)) | (mask >> 1);
	endfunction

	// ------------------------------------------------------------
	// Strobe and pace decode
	// ------------------------------------------------------------
	sarhi_state_t state_d, state_q;
	logic [11:0] sar_d, sar_q;
	logic [11:0] mask_d, mask_q;
	logic [15:0] cnt_d, cnt_q;
	logic [1:0] fall_d, fall_q;
	logic eclk_d, eclk_q;
	logic write_act, eclk_fall, step, last_bit, restart, az_int_done, az_ext_done;

	assign write_act = !cs_n_s && !wr_n_s;
	assign eclk_fall = eclk_q && !eclk_s;
	// Internal pacing spreads the remaining time evenly over the twelve steps
	assign step = ext_mode_s ? eclk_fall : (cnt_q == 16'h0000);
	assign last_bit = (mask_q == 12'h001);
	// In external mode the host's stretched write covered auto-zero; only falls count
	assign az_int_done = !ext_mode_s && (cnt_q == 16'h0000);
	assign az_ext_done = ext_mode_s && eclk_fall && (fall_q == 2'h1);
	assign restart = write_act && is_restartable(state_q);

	// ------------------------------------------------------------
	// Pace clock edge detect
	// ------------------------------------------------------------
	always_comb begin
		eclk_d = eclk_s;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			eclk_q <= 1'b0;
		end else begin
			eclk_q <= eclk_d;
		end
	end

	// ------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			SARHI_IDLE: begin
				if (write_act) begin
					state_d = SARHI_START;
				end
			end
			SARHI_START: begin
				// Held while the write stays low; auto-zero timing begins at its release
				if (!write_act) begin
					state_d = SARHI_AZ;
				end
			end
			SARHI_AZ: begin
				if (az_int_done || az_ext_done) begin
					state_d = SARHI_CONV;
				end
			end
			SARHI_CONV: begin
				if (step && last_bit) begin
					state_d = SARHI_IDLE;
				end
			end
			default: begin
				state_d = SARHI_IDLE;
			end
		endcase
		// A write during auto-zero or bit decisions starts over from the top
		if (restart) begin
			state_d = SARHI_START;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_q <= SARHI_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// Pace counters
	// ------------------------------------------------------------
	always_comb begin
		cnt_d = cnt_q;
		fall_d = fall_q;
		case (state_q)
			SARHI_START: begin
				cnt_d = 16'(AZ_CYCLES - 1);
				fall_d = 2'h0;
			end
			SARHI_AZ: begin
				if (ext_mode_s) begin
					if (eclk_fall) begin
						fall_d = fall_q + 2'h1;
					end
				end else if (az_int_done) begin
					cnt_d = 16'(STEP_CYCLES - 1);
				end else begin
					cnt_d = cnt_q - 16'h0001;
				end
			end
			SARHI_CONV: begin
				if (step) begin
					cnt_d = 16'(STEP_CYCLES - 1);
				end else if (!ext_mode_s) begin
					cnt_d = cnt_q - 16'h0001;
				end
			end
			default: begin
				cnt_d = cnt_q;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cnt_q <= 16'h0000;
			fall_q <= 2'h0;
		end else begin
			cnt_q <= cnt_d;
			fall_q <= fall_d;
		end
	end

	// ------------------------------------------------------------
	// Approximation register
	// ------------------------------------------------------------
	always_comb begin
		sar_d = sar_q;
		mask_d = mask_q;
		case (state_q)
			SARHI_START: begin
				sar_d = RESULT_RST;
				mask_d = RESULT_RST;
				// External pacing: the MSB trial must settle before the deciding fall
				if (!write_act && ext_mode_s) begin
					sar_d = MSB_ONE;
					mask_d = MSB_ONE;
				end
			end
			SARHI_AZ: begin
				if (az_int_done) begin
					sar_d = MSB_ONE;
					mask_d = MSB_ONE;
				end else if (az_ext_done) begin
					sar_d = trial_next(sar_q, mask_q, comp_s);
					mask_d = mask_q >> 1;
				end
			end
			SARHI_CONV: begin
				if (step) begin
					sar_d = trial_next(sar_q, mask_q, comp_s);
					mask_d = mask_q >> 1;
				end
			end
			default: begin
				sar_d = sar_q;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sar_q <= RESULT_RST;
			mask_q <= RESULT_RST;
		end else begin
			sar_q <= sar_d;
			mask_q <= mask_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	logic converting;
	logic busy_n_d, busy_n_q, hold_d, hold_q;
	logic [11:0] dac_d, dac_q;
	assign converting = is_running(state_q);

	// Taken from the next state so the pins move on the same edge as the sequencer
	always_comb begin
		busy_n_d = !is_running(state_d);
		hold_d = is_sampling(state_d);
		dac_d = sar_d;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			busy_n_q <= 1'b1;
			hold_q <= 1'b1;
			dac_q <= RESULT_RST;
		end else begin
			busy_n_q <= busy_n_d;
			hold_q <= hold_d;
			dac_q <= dac_d;
		end
	end
	assign busy_n = busy_n_q;
	assign hold_capacitor = hold_q;
	assign dac_code = dac_q;

	// Mid-conversion reads show the live approximation register
	sarhi_bus u_bus (
		.ref_clk(ref_clk),
		.reset(reset),
		.read_en(!cs_n_s && !rd_n_s),
		.byte_select(bsel_s),
		.converting(converting),
		.sar_bits(sar_q),
		.data_out(data_out),
		.data_oe(data_oe)
	);
endmodule

// ---- verif/sarhi_assertions.sv ----
// Port assertions for the converter host interface.
// Bound to sarhi_top from the testbench file.
`timescale 1ns/1ns
module sarhi_assertions
	import sarhi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic byte_select,
	input wire logic use_ext_clk,
	input wire logic [sarhi_pkg::BUS_W-1:0] data_out,
	input wire logic data_oe,
	input wire logic busy_n,
	input wire logic hold_capacitor,
	input wire logic [sarhi_pkg::RESULT_W-1:0] dac_code
);
	localparam int STEPS = RESULT_W * STEP_CYCLES;
	int az_q, az_d, cv_q, cv_d;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ------------------------------------------------------------
	// Phase counters
	// ------------------------------------------------------------
	always_comb begin
		az_d = (hold_capacitor && !busy_n) ? az_q + 1 : 0;
		cv_d = (!hold_capacitor && !busy_n) ? cv_q + 1 : 0;
	end
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			az_q <= 0;
			cv_q <= 0;
		end else begin
			az_q <= az_d;
			cv_q <= cv_d;
		end
	end
	sequence s_write;
		!chip_select_n && $fell(write_n);
	endsequence
	a_oe_follows_read: assert property (data_oe == $past(!chip_select_n && !read_n, 3))
		else $error("bus enable out of step");
	a_pad_zero: assert property (data_oe && $past(byte_select, 3) |-> data_out[6:4] == PAD_ZERO)
		else $error("pad bits not zero");
	a_status_flag: assert property (data_oe && $past(byte_select, 3) && $stable(busy_n)
		|-> data_out[7] != busy_n)
		else $error("status flag wrong");
	a_busy_start: assert property (s_write |-> ##[1:5] !busy_n)
		else $error("no conversion start");
	a_write_restart: assert property ((!busy_n && !hold_capacitor) ##0 s_write
		|-> ##[1:5] hold_capacitor)
		else $error("no restart");
	a_az_length: assert property ($fell(hold_capacitor) |-> az_q >= AZ_CYCLES)
		else $error("auto-zero too short");
	a_step_count: assert property ($rose(busy_n) && !use_ext_clk
		|-> cv_q inside {[STEPS-8:STEPS+8]})
		else $error("conversion length wrong");
	a_msb_first: assert property ($fell(hold_capacitor) && !use_ext_clk
		|-> ##[0:3] dac_code == MSB_ONE)
		else $error("first trial not MSB");
	a_ext_msb_trial: assert property ($fell(hold_capacitor) && use_ext_clk
		|-> $past(dac_code) == MSB_ONE)
		else $error("external first trial not MSB");
	a_idle_autozero: assert property (busy_n && $past(busy_n) |-> hold_capacitor)
		else $error("idle without auto-zero");
endmodule

// ---- verif/sarhi_host.sv ----
// Host processor model: chip select, strobes, byte select.
// Assumes its tasks are called from one process.
`timescale 1ns/1ns
module sarhi_host (
	input wire logic ref_clk,
	output logic chip_select_n,
	output logic read_n,
	output logic write_n,
	output logic byte_select
);
	initial begin
		chip_select_n = 1'b1;
		read_n = 1'b1;
		write_n = 1'b1;
		byte_select = 1'b0;
	end
	task automatic start(input int len);
		@(posedge ref_clk);
		chip_select_n <= 1'b0;
		write_n <= 1'b0;
		repeat (len) @(posedge ref_clk);
		write_n <= 1'b1;
		@(posedge ref_clk);
		chip_select_n <= 1'b1;
	endtask
	task automatic fetch(input logic hi);
		@(posedge ref_clk);
		byte_select <= hi;
		@(posedge ref_clk);
		chip_select_n <= 1'b0;
		read_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chip_select_n <= 1'b1;
		read_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
	endtask
endmodule

// ---- verif/testbench.sv ----
// Bench: host model drives strobes, bench plays the comparator.
// Assumes sarhi_top and sarhi_host are compiled first.
`timescale 1ns/1ns
module testbench;
	import sarhi_pkg::*;
	logic ref_clk, reset, chip_select_n, read_n, write_n, byte_select;
	logic ext_clk, use_ext_clk, comp_in, data_oe, busy_n, hold_capacitor;
	logic [BUS_W-1:0] data_out;
	logic [RESULT_W-1:0] dac_code, tgt;
	logic [BUS_W-1:0] exp_q[$];
	int miscompares, checked, cyc;
	sarhi_top uut (.*);
	sarhi_host host (.*);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		ext_clk = 1'b0;
		#3;
		forever #200 ext_clk = ~ext_clk;
	end
	// Comparator keeps a trial at or below the target
	always @(posedge ref_clk) comp_in <= (dac_code <= tgt);
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc > 90000) begin
			miscompares++;
			conclude();
		end
	end
	always @(posedge data_oe) begin
		@(negedge ref_clk);
		check(data_out, exp_q.pop_front());
	end
	function automatic logic [11:0] lfsr(input logic [11:0] x);
		return {x[10:0], x[11] ^ x[10] ^ x[9] ^ x[3]};
	endfunction
	task automatic check(input logic [BUS_W-1:0] got, input logic [BUS_W-1:0] want);
		checked++;
		if (got !== want) begin
			miscompares++;
			$display("Error %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic convert(input logic ext, input logic hi_first);
		logic hi;
		use_ext_clk <= ext;
		tgt <= lfsr(tgt);
		host.start(ext ? 1010 : 5);
		while (busy_n !== 1'b1) @(posedge ref_clk);
		for (int i = 0; i < 2; i++) begin
			hi = hi_first ^ i[0];
			exp_q.push_back(hi ? {1'b0, PAD_ZERO, tgt[11:8]} : tgt[7:0]);
			host.fetch(hi);
		end
	endtask
	task automatic conclude();
		$display("Counts: %0d mismatches, %0d checks", miscompares, checked);
		if (miscompares == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		use_ext_clk = 1'b0;
		tgt = 12'h03a;
		miscompares = 0;
		checked = 0;
		cyc = 0;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		check({7'h00, busy_n}, 8'h01);
		convert(1'b0, 1'b0);
		convert(1'b0, 1'b1);
		host.start(5);
		repeat (1400) @(posedge ref_clk);
		exp_q.push_back({1'b1, PAD_ZERO, MSB_ONE[11:8]});
		host.fetch(1'b1);
		repeat (1600) @(posedge ref_clk);
		convert(1'b0, 1'b1);
		convert(1'b1, 1'b0);
		convert(1'b1, 1'b1);
		conclude();
	end
endmodule
bind sarhi_top sarhi_assertions u_chk (.*);
